// file: ait_defines.vh
/*
  constants for the acquisition timing block: register offsets, field
  positions, reset values and timing counts.
  assumes a 20 MHz core clock and byte addresses on an 8-bit register port.
*/
`ifndef AIT_DEFINES_VH
`define AIT_DEFINES_VH

// core clock and settling gap between scanned channels
`define AIT_CLK_HZ 20000000
`define AIT_SETTLE_NS 10000
`define AIT_SETTLE_CYC ((`AIT_SETTLE_NS * (`AIT_CLK_HZ / 1000000) + 999) / 1000)

// engine register offsets inside a 32-byte engine window
`define AIT_R_CTRL 3'h0
`define AIT_R_DIV 3'h1
`define AIT_R_PRE 3'h2
`define AIT_R_CONVT 3'h3
`define AIT_R_STAT 3'h4
`define AIT_R_CMD 3'h5
`define AIT_R_POST 3'h6
// slot registers start here, one word per slot
`define AIT_SLOT_BASE 8'h80

// control fields
`define AIT_C_TB 1:0
`define AIT_C_START 3:2
`define AIT_C_REF 5:4
`define AIT_C_PAUSE 7:6
`define AIT_C_PPOL 8
`define AIT_C_INV 9
`define AIT_C_SYNC 10
`define AIT_C_LINE 11
`define AIT_C_SINGLE 12
`define AIT_C_REFEN 13
`define AIT_C_SWPAUSE 14

// command bits
`define AIT_CMD_COMMIT 0
`define AIT_CMD_START 1
`define AIT_CMD_REF 2
`define AIT_CMD_STOP 3

// slot fields
`define AIT_S_OWN 1:0
`define AIT_S_EN 2
`define AIT_S_TYPE 4:3
`define AIT_S_CH 8:5

// slot types
`define AIT_T_SCAN 2'h0
`define AIT_T_SSH 2'h1
`define AIT_T_OVS 2'h2
`define AIT_T_SLOW 2'h3

// timebase choices
`define AIT_TB_80M 2'h0
`define AIT_TB_100K 2'h1
`define AIT_TB_EXT 2'h2
`define AIT_TB_OVS 2'h3

// reset values
`define AIT_RST_CTRL 16'h0100
`define AIT_RST_DIV 16'h0001
`define AIT_RST_ZERO 16'h0000
`define AIT_RST_SLOT 9'h000

`endif

// file: ait_timing.v
/*
  acquisition timing: three timing engines, convert sequencing for four
  module slots, synchronisation pulses and slow-module repeat marking.
  assumes all inputs are synchronous to core_clk_in and that timebase
  inputs arrive as one-cycle tick pulses.
*/
// Added by the designer: the address map and strobed register access.
// Notes on behaviour
// - three independent engines; module owned by one
// - start, reference, pause from digital, analog, software
// - digital triggers from two parallel input slots
// - timebase selectable: 80M, 100k, external, oversample
// - sample clock on terminal, active high default
// - timebase divided down, never driven out
// - each sample starts one convert per channel
// - convert spacing is conversion time plus settling
// - too short period: spread converts evenly
// - one gap shared by all modules in task
// - simultaneous modules sample all inputs each pulse
// - only two synchronisation pulse lines exist
// - oversample clock serves as timebase, fastest default
// - sample rate is integer division of timebase
// - oversample-derived clock triggers all task modules
// - one sync pulse resets oversampling converters together
// - slow module repeats last value until done
// - slow first value at commit, second after start
// - single-point mode never repeats slow values
// - pause is level, programmable polarity, halts clock
// - reference before pretrigger count is ignored
`timescale 1ns/1ps
`include "ait_defines.vh"

module ait_timing (
  input wire core_clk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  input wire tb_80m_tick_in,
  input wire tb_100k_tick_in,
  input wire ext_tb_tick_in,
  input wire [1:0] os_tick_in,
  input wire [1:0] dig_trig_in,
  input wire analog_trig_in,
  input wire [3:0] slow_done_in,
  output reg [2:0] function_terminal_out,
  output reg [3:0] convert_out,
  output reg [3:0] simultaneous_sampling_out,
  output reg [3:0] slow_convert_out,
  output reg [3:0] slow_repeat_out,
  output reg [1:0] sync_pulse_out
);

  localparam integer SETTLE_N = `AIT_SETTLE_CYC;
  localparam [16:0] SETTLE = SETTLE_N[16:0];
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  ////////////////////////////////////////////////////////////////////////////

  // software source is selector 0, then the two digital slots, then analog
  function trig_pick;
    input [1:0] sel;
    input sw;
    input [1:0] dig;
    input ana;
    begin
      case (sel)
        2'h0: trig_pick = sw;
        2'h1: trig_pick = dig[0];
        2'h2: trig_pick = dig[1];
        default: trig_pick = ana;
      endcase
    end
  endfunction

  function eng_hit;
    input [7:0] a;
    input integer n;
    begin
      eng_hit = (a[7] == 1'b0) && (a[6:5] == n[1:0]) && (a[4:2] <= `AIT_R_POST);
    end
  endfunction

  function own_hit;
    input [8:0] cfg;
    input integer n;
    begin
      own_hit = cfg[`AIT_S_EN] && (cfg[`AIT_S_OWN] == n[1:0]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  wire [2:0] eng_samp_w;
  wire [2:0] eng_conv_w;
  wire [2:0] eng_commit_w;
  wire [2:0] eng_start_w;
  wire [2:0] eng_single_w;
  wire [2:0] eng_sync0_w;
  wire [2:0] eng_sync1_w;
  wire [2:0] eng_ft_w;
  wire [11:0] eng_idx_w;
  wire [95:0] eng_rd_w;
  wire [35:0] slot_cfg_w;

  genvar e;
  genvar s;

  generate
    for (e = 0; e < 3; e = e + 1)
    begin : g_eng
      reg [15:0] ctrl_q;
      reg [15:0] div_q;
      reg [15:0] pre_q;
      reg [15:0] post_q;
      reg [15:0] convt_q;
      reg [1:0] st_q;
      reg ovr_q;
      reg refd_q;
      reg busy_q;
      reg per_ok_q;
      reg st_prev_q;
      reg rf_prev_q;
      reg [15:0] scnt_q;
      reg [15:0] pcnt_q;
      reg [15:0] tcnt_q;
      reg [15:0] per_q;
      reg [15:0] pmeas_q;
      reg [15:0] gap_q;
      reg [3:0] idx_q;
      reg [3:0] maxch;
      reg tick;
      reg [31:0] rd;
      reg [15:0] spc;
      integer i;

      wire sel_w = reg_wr_in && eng_hit(reg_addr_in, e);
      wire [2:0] ro_w = reg_addr_in[4:2];
      wire cmd_w = sel_w && (ro_w == `AIT_R_CMD);
      wire commit_w = cmd_w && reg_wdata_in[`AIT_CMD_COMMIT] && (st_q == ST_IDLE);
      wire stop_w = cmd_w && reg_wdata_in[`AIT_CMD_STOP];
      wire sw_start_w = cmd_w && reg_wdata_in[`AIT_CMD_START];
      wire sw_ref_w = cmd_w && reg_wdata_in[`AIT_CMD_REF];
      // trigger sources; edges for start and reference, level for pause
      wire start_lv_w = trig_pick(ctrl_q[`AIT_C_START], sw_start_w, dig_trig_in,
                                  analog_trig_in);
      wire ref_lv_w = trig_pick(ctrl_q[`AIT_C_REF], sw_ref_w, dig_trig_in, analog_trig_in);
      wire paused_w = trig_pick(ctrl_q[`AIT_C_PAUSE], ctrl_q[`AIT_C_SWPAUSE], dig_trig_in,
                                analog_trig_in) == ctrl_q[`AIT_C_PPOL];
      wire start_w = (st_q == ST_ARMED) && start_lv_w && !st_prev_q;
      wire ref_w = (st_q == ST_RUN) && ref_lv_w && !rf_prev_q;
      wire [15:0] divm1_w = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
      wire samp_w = (st_q == ST_RUN) && tick && !paused_w && (tcnt_q >= divm1_w);
      wire acc_w = samp_w && !busy_q;
      wire [16:0] full_w = {1'b0, convt_q} + SETTLE;
      wire [20:0] need_w = maxch * full_w;
      wire even_w = per_ok_q && (need_w > {5'h00, per_q});

      // timebase choice; only its divided result leaves the block
      always @*
      begin
        case (ctrl_q[`AIT_C_TB])
          `AIT_TB_80M: tick = tb_80m_tick_in;
          `AIT_TB_100K: tick = tb_100k_tick_in;
          `AIT_TB_EXT: tick = ext_tb_tick_in;
          // line 0 carries the fastest oversample clock unless line 1 is picked
          default: tick = os_tick_in[ctrl_q[`AIT_C_LINE]];
        endcase
      end

      // widest scanned module sets the sequence length of the task
      always @*
      begin
        maxch = 4'h0;
        for (i = 0; i < 4; i = i + 1)
        begin
          if (own_hit(slot_cfg_w[i*9 +: 9], e) &&
              (slot_cfg_w[i*9+3 +: 2] == `AIT_T_SCAN) &&
              (slot_cfg_w[i*9+5 +: 4] > maxch))
          begin
            maxch = slot_cfg_w[i*9+5 +: 4];
          end
        end
      end

      always @*
      begin
        if (even_w && (maxch != 4'h0))
        begin
          spc = per_q / {12'h000, maxch};
        end
        else
        begin
          spc = full_w[16] ? 16'hffff : full_w[15:0];
        end
      end

      always @*
      begin
        case (ro_w)
          `AIT_R_CTRL: rd = {16'h0000, ctrl_q};
          `AIT_R_DIV: rd = {16'h0000, div_q};
          `AIT_R_PRE: rd = {16'h0000, pre_q};
          `AIT_R_CONVT: rd = {16'h0000, convt_q};
          `AIT_R_STAT: rd = {scnt_q, 9'h000, busy_q, refd_q, ovr_q, paused_w, 1'b0, st_q};
          `AIT_R_POST: rd = {16'h0000, post_q};
          default: rd = 32'h00000000;
        endcase
      end

      always @(posedge core_clk_in)
      begin
        if (rst_in)
        begin
          ctrl_q <= `AIT_RST_CTRL;
          div_q <= `AIT_RST_DIV;
          pre_q <= `AIT_RST_ZERO;
          post_q <= `AIT_RST_ZERO;
          convt_q <= `AIT_RST_ZERO;
          st_q <= ST_IDLE;
          ovr_q <= 1'b0;
          refd_q <= 1'b0;
          busy_q <= 1'b0;
          per_ok_q <= 1'b0;
          st_prev_q <= 1'b0;
          rf_prev_q <= 1'b0;
          scnt_q <= 16'h0000;
          pcnt_q <= 16'h0000;
          tcnt_q <= 16'h0000;
          per_q <= 16'h0000;
          pmeas_q <= 16'h0000;
          gap_q <= 16'h0000;
          idx_q <= 4'h0;
        end
        else
        begin
          st_prev_q <= start_lv_w;
          rf_prev_q <= ref_lv_w;
          if (sel_w && (ro_w == `AIT_R_CTRL))
          begin
            ctrl_q <= reg_wdata_in[15:0];
          end
          if (sel_w && (ro_w == `AIT_R_DIV))
          begin
            div_q <= reg_wdata_in[15:0];
          end
          if (sel_w && (ro_w == `AIT_R_PRE))
          begin
            pre_q <= reg_wdata_in[15:0];
          end
          if (sel_w && (ro_w == `AIT_R_CONVT))
          begin
            convt_q <= reg_wdata_in[15:0];
          end
          if (sel_w && (ro_w == `AIT_R_POST))
          begin
            post_q <= reg_wdata_in[15:0];
          end
          // divider counts timebase ticks, frozen while paused
          if ((st_q == ST_RUN) && tick && !paused_w)
          begin
            tcnt_q <= samp_w ? 16'h0000 : tcnt_q + 16'h0001;
          end
          // sample period in core cycles, for even spacing
          if (samp_w)
          begin
            per_q <= pmeas_q;
            per_ok_q <= 1'b1;
            pmeas_q <= 16'h0000;
          end
          else if (pmeas_q != 16'hffff)
          begin
            pmeas_q <= pmeas_q + 16'h0001;
          end
          // convert sequencer
          if (acc_w)
          begin
            busy_q <= (maxch > 4'h1);
            idx_q <= 4'h0;
            gap_q <= (spc == 16'h0000) ? 16'h0000 : spc - 16'h0001;
          end
          else if (busy_q)
          begin
            if (gap_q == 16'h0000)
            begin
              idx_q <= idx_q + 4'h1;
              busy_q <= (idx_q + 4'h2) < maxch;
              gap_q <= (spc == 16'h0000) ? 16'h0000 : spc - 16'h0001;
            end
            else
            begin
              gap_q <= gap_q - 16'h0001;
            end
          end
          // overrun: a sample pulse while converts are still running
          if (commit_w)
          begin
            ovr_q <= 1'b0;
          end
          if (samp_w && busy_q)
          begin
            ovr_q <= 1'b1;
          end
          case (st_q)
            ST_IDLE:
            begin
              if (commit_w)
              begin
                st_q <= ST_ARMED;
                scnt_q <= 16'h0000;
                pcnt_q <= 16'h0000;
                refd_q <= 1'b0;
                tcnt_q <= 16'h0000;
                per_ok_q <= 1'b0;
              end
            end
            ST_ARMED:
            begin
              if (stop_w)
              begin
                st_q <= ST_IDLE;
              end
              else if (start_w)
              begin
                st_q <= ST_RUN;
              end
            end
            ST_RUN:
            begin
              if (stop_w)
              begin
                st_q <= ST_IDLE;
              end
              else
              begin
                if (acc_w)
                begin
                  if (scnt_q != 16'hffff)
                  begin
                    scnt_q <= scnt_q + 16'h0001;
                  end
                  if (refd_q)
                  begin
                    pcnt_q <= pcnt_q + 16'h0001;
                    if ((pcnt_q + 16'h0001) >= post_q)
                    begin
                      st_q <= ST_IDLE;
                    end
                  end
                end
                if (ref_w && ctrl_q[`AIT_C_REFEN] && !refd_q && (scnt_q >= pre_q))
                begin
                  refd_q <= 1'b1;
                end
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end

      assign eng_samp_w[e] = acc_w;
      assign eng_conv_w[e] = acc_w || (busy_q && (gap_q == 16'h0000));
      assign eng_idx_w[e*4 +: 4] = acc_w ? 4'h0 : idx_q + 4'h1;
      assign eng_commit_w[e] = commit_w;
      assign eng_start_w[e] = start_w;
      assign eng_single_w[e] = ctrl_q[`AIT_C_SINGLE];
      assign eng_sync0_w[e] = start_w && ctrl_q[`AIT_C_SYNC] && !ctrl_q[`AIT_C_LINE];
      assign eng_sync1_w[e] = start_w && ctrl_q[`AIT_C_SYNC] && ctrl_q[`AIT_C_LINE];
      assign eng_ft_w[e] = acc_w ^ ctrl_q[`AIT_C_INV];
      assign eng_rd_w[e*32 +: 32] = rd;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////

  // module slots: each slot belongs to exactly one engine
  generate
    for (s = 0; s < 4; s = s + 1)
    begin : g_slot
      reg [8:0] cfg_q;
      reg fresh_q;
      reg busy_q;
      wire [1:0] own_w = cfg_q[`AIT_S_OWN];
      wire en_w = cfg_q[`AIT_S_EN];
      wire [1:0] ty_w = cfg_q[`AIT_S_TYPE];
      wire samp_w = en_w && eng_samp_w[own_w];
      wire slow_w = en_w && (ty_w == `AIT_T_SLOW);
      wire single_w = eng_single_w[own_w];
      // first conversion at commit, second at start, then on demand
      wire slow_go_w = slow_w && (eng_commit_w[own_w] || eng_start_w[own_w] ||
                                  (samp_w && (!busy_q || single_w)));

      always @(posedge core_clk_in)
      begin
        if (rst_in)
        begin
          cfg_q <= `AIT_RST_SLOT;
          fresh_q <= 1'b0;
          busy_q <= 1'b0;
          convert_out[s] <= 1'b0;
          simultaneous_sampling_out[s] <= 1'b0;
          slow_convert_out[s] <= 1'b0;
          slow_repeat_out[s] <= 1'b0;
        end
        else
        begin
          if (reg_wr_in && (reg_addr_in == (`AIT_SLOT_BASE + s * 4)))
          begin
            cfg_q <= reg_wdata_in[8:0];
          end
          convert_out[s] <= en_w && (ty_w == `AIT_T_SCAN) && eng_conv_w[own_w] &&
                            (eng_idx_w[own_w*4 +: 4] < cfg_q[`AIT_S_CH]);
          // simultaneous and oversampling modules take the whole sample at once
          simultaneous_sampling_out[s] <= samp_w && (ty_w != `AIT_T_SCAN) &&
                                          (ty_w != `AIT_T_SLOW);
          slow_convert_out[s] <= slow_go_w;
          if (samp_w && slow_w)
          begin
            slow_repeat_out[s] <= !fresh_q && !single_w;
          end
          // a completion in the same cycle as a sample counts as fresh next time
          if (samp_w)
          begin
            fresh_q <= 1'b0;
          end
          if (slow_done_in[s])
          begin
            fresh_q <= 1'b1;
          end
          if (slow_done_in[s])
          begin
            busy_q <= 1'b0;
          end
          if (slow_go_w)
          begin
            busy_q <= 1'b1;
          end
        end
      end

      assign slot_cfg_w[s*9 +: 9] = cfg_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////

  // shared outputs and register read port
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      function_terminal_out <= 3'h0;
      sync_pulse_out <= 2'h0;
      reg_rdata_out <= 32'h00000000;
    end
    else
    begin
      function_terminal_out <= eng_ft_w;
      sync_pulse_out <= {|eng_sync1_w, |eng_sync0_w};
      if (reg_rd_in)
      begin
        if (reg_addr_in[7] && (reg_addr_in[6:4] == 3'h0) && (reg_addr_in[1:0] == 2'h0))
        begin
          reg_rdata_out <= {23'h000000, slot_cfg_w[reg_addr_in[3:2]*9 +: 9]};
        end
        else if (!reg_addr_in[7] && (reg_addr_in[6:5] != 2'h3) &&
                 (reg_addr_in[1:0] == 2'h0))
        begin
          reg_rdata_out <= eng_rd_w[reg_addr_in[6:5]*32 +: 32];
        end
        else
        begin
          reg_rdata_out <= 32'h00000000;
        end
      end
      else
      begin
        reg_rdata_out <= 32'h00000000;
      end
    end
  end

endmodule // ait_timing

// file: ait_timing_sva.sv
/*
  checker for ait_timing: pulse widths and the causes of module pulses.
  assumes one clock domain and a bind onto every ait_timing instance.
*/
`timescale 1ns/1ps
module ait_timing_sva (
  input wire core_clk_in,
  input wire rst_in,
  input wire [2:0] function_terminal_out,
  input wire [3:0] convert_out,
  input wire [3:0] simultaneous_sampling_out,
  input wire [3:0] slow_convert_out,
  input wire [3:0] slow_repeat_out,
  input wire [1:0] sync_pulse_out
);
  reg seen_q;
  wire seen_d;
  // set once any engine has issued a sample
  assign seen_d = seen_q | (|function_terminal_out);
  always @(posedge core_clk_in)
  begin
    if (rst_in)
      seen_q <= 1'b0;
    else
      seen_q <= seen_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_conv_one: assert property ((convert_out & $past(convert_out)) == 4'h0)
    else $error("convert pulse wider than one cycle");
  chk_conv_cause: assert property (|convert_out |-> seen_d)
    else $error("convert pulse without a sample");
  chk_ssh_with_clock: assert property (|simultaneous_sampling_out |-> |function_terminal_out)
    else $error("simultaneous pulse apart from sample clock");
  chk_ssh_one: assert property ($rose(simultaneous_sampling_out[1]) |=> !simultaneous_sampling_out[1])
    else $error("simultaneous pulse wider than one cycle");
  chk_sync_one: assert property ($rose(sync_pulse_out[0]) |=> !sync_pulse_out[0] [*2])
    else $error("sync pulse repeated or wide");
  chk_slow_one: assert property ((slow_convert_out & $past(slow_convert_out)) == 4'h0)
    else $error("slow convert pulse wider than one cycle");
  chk_repeat_cause: assert property (|slow_repeat_out |-> seen_d)
    else $error("repeat flag without a sample");
  chk_clk_one: assert property ((function_terminal_out & $past(function_terminal_out)) == 3'h0)
    else $error("sample clock output held high");
  chk_reset_quiet: assert property ($fell(rst_in) |-> function_terminal_out == 3'h0 && convert_out == 4'h0)
    else $error("pulses right after reset");
endmodule // ait_timing_sva

bind ait_timing ait_timing_sva ait_timing_sva_inst (
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .function_terminal_out(function_terminal_out), .convert_out(convert_out),
  .simultaneous_sampling_out(simultaneous_sampling_out),
  .slow_convert_out(slow_convert_out), .slow_repeat_out(slow_repeat_out),
  .sync_pulse_out(sync_pulse_out));

// file: ait_slow_model.sv
/*
  model of slow converter modules: each start-conversion pulse is
  answered by a done pulse DONE_CYC cycles later; a new start restarts it.
  assumes pulses synchronous to core_clk_in.
*/
`timescale 1ns/1ps
module ait_slow_model #(
  parameter DONE_CYC = 1200
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire [3:0] slow_convert_in,
  output reg [3:0] slow_done_out
);
  int cnt [4];
  always @(posedge core_clk_in)
  begin
    for (int i = 0; i < 4; i++)
    begin
      slow_done_out[i] <= 1'b0;
      if (rst_in)
        cnt[i] <= 0;
      else if (slow_convert_in[i])
        cnt[i] <= DONE_CYC;
      else if (cnt[i] != 0)
      begin
        cnt[i] <= cnt[i] - 1;
        slow_done_out[i] <= (cnt[i] == 1);
      end
    end
  end
endmodule // ait_slow_model

// file: test_ait_timing.sv
/*
  testbench for ait_timing: register tasks drive sampling, pause,
  reference and sync sequences on the three engines.
  assumes the slow module model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
module test_ait_timing;
  reg core_clk_in, rst_in, reg_wr_in, reg_rd_in, tb_80m_tick_in, analog_trig_in, os_en;
  reg [7:0] reg_addr_in;
  reg [31:0] reg_wdata_in;
  reg [1:0] os_tick_in, dig_trig_in;
  wire [31:0] reg_rdata_out;
  wire [2:0] function_terminal_out;
  wire [3:0] convert_out, simultaneous_sampling_out, slow_convert_out;
  wire [3:0] slow_repeat_out, slow_done_in;
  wire [1:0] sync_pulse_out;
  wire [16:0] mon;
  int fails, n_checks, n;
  logic [31:0] d;
  // pause table: analog level, digital levels, control word
  logic [18:0] pz [4] = '{19'h04100, 19'h10140, 19'h00080, 19'h401c0};
  assign mon = {sync_pulse_out, slow_convert_out, simultaneous_sampling_out,
    convert_out, function_terminal_out};
  ait_timing ait_timing_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tb_80m_tick_in(tb_80m_tick_in),
    .tb_100k_tick_in(1'b0), .ext_tb_tick_in(os_tick_in[0]), .os_tick_in(os_tick_in),
    .dig_trig_in(dig_trig_in), .analog_trig_in(analog_trig_in),
    .slow_done_in(slow_done_in), .function_terminal_out(function_terminal_out),
    .convert_out(convert_out), .simultaneous_sampling_out(simultaneous_sampling_out),
    .slow_convert_out(slow_convert_out), .slow_repeat_out(slow_repeat_out),
    .sync_pulse_out(sync_pulse_out));
  ait_slow_model #(.DONE_CYC(1200)) ait_slow_model_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .slow_convert_in(slow_convert_out), .slow_done_out(slow_done_in));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // oversample line 0 ticks every second cycle once enabled
  always @(posedge core_clk_in)
  begin
    os_tick_in <= {1'b0, os_en & ~os_tick_in[0]};
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out();
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    v = reg_rdata_out;
  endtask
  // cycles until the monitored bit is high; running out ends the run
  task wait_bit(input int k, input int lim, output int c);
    c = 0;
    do
    begin
      @(posedge core_clk_in);
      #1;
      c++;
    end
    while (mon[k] !== 1'b1 && c < lim);
    if (mon[k] !== 1'b1)
    begin
      fails++;
      close_out();
    end
  endtask
  task count_bit(input int k, input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(posedge core_clk_in);
      #1;
      if (mon[k] === 1'b1)
        c++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    tb_80m_tick_in = 1'b0;
    analog_trig_in = 1'b0;
    os_en = 1'b0;
    os_tick_in = 2'h0;
    dig_trig_in = 2'h0;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(8'h00, d); chk(d, 32'h100);
    rd(8'h24, d); chk(d, 32'h1);
    rd(8'h50, d); chk(d, 32'h0);
    rd(8'h60, d); chk(d, 32'h0);
    // engine 0: scan slot 0, simultaneous slot 1, slow slot 3
    wr(8'h80, 32'h44);
    wr(8'h84, 32'h8c);
    wr(8'h8c, 32'h3c);
    rd(8'h80, d); chk(d, 32'h44);
    wr(8'h04, 32'h1f4);
    tb_80m_tick_in <= 1'b1;
    wr(8'h14, 32'h1);
    #1;
    chk({31'h0, mon[14]}, 32'h1);
    rd(8'h10, d); chk(d & 32'h3, 32'h1);
    wr(8'h14, 32'h2);
    #1;
    chk({31'h0, mon[14]}, 32'h1);
    wait_bit(0, 600, n);
    chk({26'h0, mon[8:3]}, 32'h21);
    wait_bit(3, 300, n); chk(32'(n), 32'd200);
    wait_bit(0, 600, n); chk(32'(n), 32'd300);
    @(posedge core_clk_in);
    #1;
    chk({31'h0, slow_repeat_out[3]}, 32'h1);
    wait_bit(0, 600, n);
    @(posedge core_clk_in);
    #1;
    chk({31'h0, slow_repeat_out[3]}, 32'h0);
    rd(8'h10, d); chk(d & 32'h10, 32'h0);
    // every pause source and both polarities hold the sample clock
    for (int i = 0; i < 4; i++)
    begin
      analog_trig_in <= pz[i][18];
      dig_trig_in <= pz[i][17:16];
      wr(8'h00, {16'h0, pz[i][15:0]});
      count_bit(0, 600, n); chk(32'(n), 32'h0);
      rd(8'h10, d); chk(d & 32'h8, 32'h8);
    end
    analog_trig_in <= 1'b0;
    dig_trig_in <= 2'h0;
    // single-point from here: slow module restarts at every sample, no repeat
    wr(8'h00, 32'h1100);
    wait_bit(0, 600, n);
    wait_bit(0, 600, n); chk(32'(n), 32'd500);
    chk({30'h0, mon[14], slow_repeat_out[3]}, 32'h2);
    // engine 2: reference before the pretrigger count is ignored
    wr(8'h44, 32'h4);
    wr(8'h48, 32'd100);
    wr(8'h40, 32'h2100);
    wr(8'h54, 32'h1);
    wr(8'h54, 32'h2);
    wr(8'h54, 32'h4);
    repeat (20) @(posedge core_clk_in);
    rd(8'h50, d); chk(d & 32'h3, 32'h2);
    repeat (500) @(posedge core_clk_in);
    wr(8'h54, 32'h4);
    repeat (20) @(posedge core_clk_in);
    rd(8'h50, d); chk(d & 32'h3, 32'h0);
    // engine 1: oversampling slot 2 timed from oversample line 0
    wr(8'h88, 32'h35);
    wr(8'h24, 32'h4);
    wr(8'h20, 32'h503);
    os_en <= 1'b1;
    wr(8'h34, 32'h1);
    wr(8'h34, 32'h2);
    #1;
    chk({31'h0, mon[15]}, 32'h1);
    wait_bit(1, 40, n);
    chk({31'h0, mon[9]}, 32'h1);
    wait_bit(1, 40, n); chk(32'(n), 32'd8);
    // engine 2 on the external timebase: one sample per four ticks
    wr(8'h40, 32'h102);
    wr(8'h54, 32'h1);
    wr(8'h54, 32'h2);
    repeat (16) @(posedge core_clk_in);
    count_bit(2, 80, n); chk(32'(n), 32'd10);
    close_out();
  end
endmodule // test_ait_timing
